// [logic/rpmc_sync.v]
`timescale 1ns/1ns

module rpmc_sync #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire [W-1:0] async_i,
   output reg  [W-1:0] sync_o
);

   reg [W-1:0] meta;

   // Resets to zero, so supplies read bad for two edges after release
   // Two flops; the first is read by the second only
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta   <= {W{1'b0}};
         sync_o <= {W{1'b0}};
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule // rpmc_sync

// [logic/rpmc_top.v]
// Overview of operation
// - Five reset causes: power-on, external pin, software, watchdog, supply dip.
// - Software write to system_reset_request starts a software reset.
// - Watchdog reset needs config-zero enable; watchdog_control steers it.
// - Supply dip reset enabled by config-one, which also holds threshold level.
// - External, software, watchdog resets last 2^17 clock cycles.
// - Supply dip reset lasts 2^15 clock cycles.
// - Digital pins pulled high from reset initiation until completion.
// - Pin high stops device and oscillator, pins high; falling edge starts count.
// - Power-on reset released when digital supply detector reports good.
// - Dip enabled and supply low holds state; rising back issues reset.
// - Analog supply below threshold keeps device held in reset.
// - Threshold uncalibrated during reset; flagged to the analog comparator.
// - Setting idle bit in power_control enters idle mode.
// - Idle stops core, timers zero and one, serial ports; rest runs.
// - Any enabled active interrupt returns idle to active operation.
// - peripheral_power_down switches off peripherals; all ones powers all down.
// - Setting stop bit enters stop mode; all internal clocks halted.
// - Stop left only by external pin or power-on reset, not interrupts; here any internal reset or a power_control write clears it.
// - In stop mode digital outputs hold their values.
`timescale 1ns/1ns
`include "rpmc_map.vh"

module rpmc_top #(
   parameter integer EXT_HOLD_CYC = `RPMC_EXT_HOLD_CYC,
   parameter integer DIP_HOLD_CYC = `RPMC_DIP_HOLD_CYC,
   parameter integer WDOG_SHIFT   = `RPMC_WDOG_SHIFT
) (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       por_ok_i,
   input  wire       ana_ok_i,
   input  wire       dip_below_i,
   input  wire       ext_pin_i,
   input  wire [7:0] hardware_config_zero_i,
   input  wire [7:0] hardware_config_one_i,
   input  wire       irq_pending_i,
   input  wire [7:0] sfr_addr_i,
   input  wire       sfr_wr_i,
   input  wire       sfr_rd_i,
   input  wire [7:0] sfr_wdata_i,
   output reg  [7:0] sfr_rdata_o,
   output reg        sys_rst_o,
   output reg        pins_high_o,
   output reg        osc_stop_o,
   output reg        state_hold_o,
   output reg        dip_uncal_o,
   output reg  [3:0] dip_level_o,
   output reg        core_halt_o,
   output reg        timer01_halt_o,
   output reg        serial_halt_o,
   output reg        clk_halt_o,
   output reg        pin_freeze_o,
   output reg  [7:0] periph_off_o
);

   localparam CW = `RPMC_HOLD_CNT_W;
   localparam [CW-1:0] EXT_N = EXT_HOLD_CYC[CW-1:0];
   localparam [CW-1:0] DIP_N = DIP_HOLD_CYC[CW-1:0];
   localparam [CW-1:0] ONE   = {{(CW-1){1'b0}}, 1'b1};

   // Register address match, used for reads and writes
   function rpmc_hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         rpmc_hit = (addr == target);
      end
   endfunction

   // Synchronised pin levels
   wire [3:0] pins_s;
   wire       por_s;
   wire       ana_s;
   wire       below_s;
   wire       ext_s;

   // Mode and control registers
   reg        idle;
   reg        stop;
   reg  [7:0] periph_pd;
   reg  [7:0] wdog_ctl;
   reg  [4:0] last_cause;

   // Reset sequencing state
   reg  [CW-1:0] cnt;
   reg           ext_q;
   reg           dip_low_q;
   reg  [CW-1:0] next_cnt;
   reg           next_rst;

   // Decoded events
   wire       dip_en;
   wire       dip_low;
   wire       ext_fall;
   wire       dip_rise;
   wire       sw_req;
   wire       wdog_exp;
   wire       wdog_en;
   wire       wdog_kick;
   wire       hold_rst;
   wire       wr_ok;

   // The external pin and the three supply inputs pass two flops first; config and irq inputs do not
   rpmc_sync #(
      .W (4)
   ) u_sync (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .async_i   ({ext_pin_i, dip_below_i, ana_ok_i, por_ok_i}),
      .sync_o    (pins_s)
   );

   assign por_s   = pins_s[0];
   assign ana_s   = pins_s[1];
   assign below_s = pins_s[2];
   assign ext_s   = pins_s[3];

   // Supply dip detection only when configured
   assign dip_en   = hardware_config_one_i[`RPMC_HC1_DIP_EN_BIT];
   assign dip_low  = dip_en && below_s;
   assign dip_rise = dip_low_q && !dip_low && dip_en;

   // Pin need only be seen high on the previous sample for its falling edge to count
   assign ext_fall = ext_q && !ext_s;

   // Writes are ignored while reset or the dip hold is active
   assign wr_ok  = sfr_wr_i && !sys_rst_o && !dip_low;
   assign sw_req = wr_ok && rpmc_hit(sfr_addr_i, `RPMC_ADR_SYS_RST_REQ)
                   && sfr_wdata_i[`RPMC_SRR_GO_BIT];

   // Watchdog enabled by the config bit and by the control bit together
   assign wdog_en   = hardware_config_zero_i[`RPMC_HC0_WDOG_EN_BIT]
                      && wdog_ctl[`RPMC_WDC_EN_BIT];
   assign wdog_kick = wr_ok && rpmc_hit(sfr_addr_i, `RPMC_ADR_WDOG_CONTROL)
                      && sfr_wdata_i[`RPMC_WDC_KICK_BIT];

   rpmc_watchdog #(
      .SHIFT (WDOG_SHIFT)
   ) u_wdog (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clear_i  (sys_rst_o),
      .enable_i (wdog_en),
      .kick_i   (wdog_kick),
      .sel_i    (wdog_ctl[`RPMC_WDC_SEL_MSB:`RPMC_WDC_SEL_LSB]),
      .expire_o (wdog_exp)
   );

   // Levels that keep reset asserted regardless of the count
   // The count stays frozen under these, so a long pin press never shortens
   // the stretch that follows its falling edge
   assign hold_rst = !por_s
                     || !ana_s
                     || ext_s;

   // Reset count: latest cause reloads, longer stretch wins a tie
   always @* begin
      next_cnt = cnt;
      if (ext_fall || sw_req || wdog_exp) begin
         next_cnt = EXT_N;
      end else if (dip_rise) begin
         next_cnt = DIP_N;
      end else if (hold_rst) begin
         next_cnt = cnt;
      end else if (cnt != {CW{1'b0}}) begin
         next_cnt = cnt - ONE;
      end
      next_rst = hold_rst || (next_cnt != {CW{1'b0}});
   end

   // Edge trackers and the count itself
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt       <= {CW{1'b0}};
         ext_q     <= 1'b0;
         dip_low_q <= 1'b0;
      end else begin
         cnt       <= next_cnt;
         ext_q     <= ext_s;
         dip_low_q <= dip_low;
      end
   end

   // Last cause survives the internal reset so software can read it
   // Power-on wins, since a supply loss makes any other cause meaningless
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         last_cause <= 5'h01;
      end else if (!por_s) begin
         last_cause <= 5'h01;
      end else if (ext_fall) begin
         last_cause <= 5'h02;
      end else if (sw_req) begin
         last_cause <= 5'h04;
      end else if (wdog_exp) begin
         last_cause <= 5'h08;
      end else if (dip_rise) begin
         last_cause <= 5'h10;
      end
   end

   // Power modes; stop clears only through the internal reset or a power_control write
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         idle <= 1'b0;
         stop <= 1'b0;
      end else if (sys_rst_o) begin
         idle <= 1'b0;
         stop <= 1'b0;
      end else begin
         if (wr_ok && rpmc_hit(sfr_addr_i, `RPMC_ADR_POWER_CONTROL)) begin
            idle <= sfr_wdata_i[`RPMC_PC_IDLE_BIT];
            stop <= sfr_wdata_i[`RPMC_PC_STOP_BIT];
         end else if (irq_pending_i) begin
            idle <= 1'b0;
         end
      end
   end

   // Peripheral power-down and watchdog control registers
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         periph_pd <= `RPMC_RST_PERIPH_PWR_DN;
         wdog_ctl  <= `RPMC_RST_WDOG_CONTROL;
      end else if (sys_rst_o) begin
         periph_pd <= `RPMC_RST_PERIPH_PWR_DN;
         wdog_ctl  <= `RPMC_RST_WDOG_CONTROL;
      end else if (wr_ok) begin
         if (rpmc_hit(sfr_addr_i, `RPMC_ADR_PERIPH_PWR_DN)) begin
            periph_pd <= sfr_wdata_i;
         end
         if (rpmc_hit(sfr_addr_i, `RPMC_ADR_WDOG_CONTROL)) begin
            // Kick bit is a strobe and is not stored
            wdog_ctl <= sfr_wdata_i & 8'hdf;
         end
      end
   end

   // Read port; unmapped addresses answer zero
   // Data is registered, so it is valid one edge after the read strobe
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sfr_rdata_o <= `RPMC_RDATA_UNMAPPED;
      end else if (sfr_rd_i) begin
         if (rpmc_hit(sfr_addr_i, `RPMC_ADR_POWER_CONTROL)) begin
            sfr_rdata_o <= {6'h00, stop, idle};
         end else if (rpmc_hit(sfr_addr_i, `RPMC_ADR_PERIPH_PWR_DN)) begin
            sfr_rdata_o <= periph_pd;
         end else if (rpmc_hit(sfr_addr_i, `RPMC_ADR_SYS_RST_REQ)) begin
            sfr_rdata_o <= {3'h0, last_cause};
         end else if (rpmc_hit(sfr_addr_i, `RPMC_ADR_WDOG_CONTROL)) begin
            sfr_rdata_o <= wdog_ctl;
         end else begin
            sfr_rdata_o <= `RPMC_RDATA_UNMAPPED;
         end
      end
   end

   // Reset, pin and supply outputs, all registered
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sys_rst_o    <= 1'b1;
         pins_high_o  <= 1'b1;
         osc_stop_o   <= 1'b0;
         state_hold_o <= 1'b0;
         dip_uncal_o  <= 1'b1;
         dip_level_o  <= 4'h0;
      end else begin
         sys_rst_o    <= next_rst;
         pins_high_o  <= next_rst;
         osc_stop_o   <= ext_s;
         state_hold_o <= dip_low;
         // Comparator runs uncalibrated, about a quarter high, in reset
         dip_uncal_o  <= next_rst;
         dip_level_o  <= hardware_config_one_i[`RPMC_HC1_LVL_MSB:`RPMC_HC1_LVL_LSB];
      end
   end

   // Clock gating controls; the gate outside must reopen on the pin itself,
   // since no edge arrives here while stopped
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_halt_o    <= 1'b0;
         timer01_halt_o <= 1'b0;
         serial_halt_o  <= 1'b0;
         clk_halt_o     <= 1'b0;
         pin_freeze_o   <= 1'b0;
         periph_off_o   <= `RPMC_RST_PERIPH_PWR_DN;
      end else begin
         core_halt_o    <= (idle || stop) && !next_rst;
         timer01_halt_o <= (idle || stop) && !next_rst;
         serial_halt_o  <= (idle || stop) && !next_rst;
         clk_halt_o     <= stop && !next_rst;
         pin_freeze_o   <= stop && !next_rst;
         periph_off_o   <= periph_pd;
      end
   end

endmodule // rpmc_top

// [logic/rpmc_watchdog.v]
`timescale 1ns/1ns
`include "rpmc_map.vh"

module rpmc_watchdog #(
   parameter SHIFT = `RPMC_WDOG_SHIFT
) (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       clear_i,
   input  wire       enable_i,
   input  wire       kick_i,
   input  wire [4:0] sel_i,
   output reg        expire_o
);

   localparam CW = SHIFT + 5;

   reg  [CW-1:0] cnt;
   wire          at_limit;

   // Period is (sel + 1) prescale ticks
   assign at_limit = (cnt[CW-1:SHIFT] == sel_i) && (&cnt[SHIFT-1:0]);

   // Counter restarts on kick, on disable and under system reset
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt      <= {CW{1'b0}};
         expire_o <= 1'b0;
      end else if (clear_i || !enable_i || kick_i) begin
         cnt      <= {CW{1'b0}};
         expire_o <= 1'b0;
      end else begin
         cnt      <= at_limit ? {CW{1'b0}} : cnt + {{(CW-1){1'b0}}, 1'b1};
         expire_o <= at_limit;
      end
   end

endmodule // rpmc_watchdog

// [pkg/rpmc_map.vh]
`ifndef RPMC_MAP_VH
`define RPMC_MAP_VH

// Special function register addresses
`define RPMC_ADR_POWER_CONTROL  8'h87
`define RPMC_ADR_PERIPH_PWR_DN  8'hf1
`define RPMC_ADR_SYS_RST_REQ    8'hf7
`define RPMC_ADR_WDOG_CONTROL   8'hff

// Register reset values
`define RPMC_RST_POWER_CONTROL  8'h00
`define RPMC_RST_PERIPH_PWR_DN  8'h00
`define RPMC_RST_WDOG_CONTROL   8'h00
`define RPMC_RDATA_UNMAPPED     8'h00

// power_control fields
`define RPMC_PC_IDLE_BIT        0
`define RPMC_PC_STOP_BIT        1

// system_reset_request fields
`define RPMC_SRR_GO_BIT         0

// watchdog_control fields
`define RPMC_WDC_EN_BIT         7
`define RPMC_WDC_KICK_BIT       5
`define RPMC_WDC_SEL_MSB        4
`define RPMC_WDC_SEL_LSB        0

// Hardware configuration fields
`define RPMC_HC0_WDOG_EN_BIT    3
`define RPMC_HC1_DIP_EN_BIT     1
`define RPMC_HC1_LVL_MSB        7
`define RPMC_HC1_LVL_LSB        4

// Last reset cause bit positions
`define RPMC_CAUSE_POR          0
`define RPMC_CAUSE_EXT          1
`define RPMC_CAUSE_SW           2
`define RPMC_CAUSE_WDOG         3
`define RPMC_CAUSE_DIP          4

// Reset stretch: two to the power of these exponents, in clock cycles
`define RPMC_EXT_HOLD_EXP       17
`define RPMC_DIP_HOLD_EXP       15
`define RPMC_EXT_HOLD_CYC       (1 << `RPMC_EXT_HOLD_EXP)
`define RPMC_DIP_HOLD_CYC       (1 << `RPMC_DIP_HOLD_EXP)
`define RPMC_HOLD_CNT_W         18

// Watchdog prescale exponent
`define RPMC_WDOG_SHIFT         10

`endif

// [tb/rpmc_props.sv]
`timescale 1ns/1ns
module rpmc_props #(
   parameter integer EXT_HOLD_CYC = 64
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       por_ok_i,
   input wire logic       ana_ok_i,
   input wire logic       ext_pin_i,
   input wire logic       dip_below_i,
   input wire logic [7:0] hardware_config_one_i,
   input wire logic       irq_pending_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic       sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic       sys_rst_o,
   input wire logic       pins_high_o,
   input wire logic       osc_stop_o,
   input wire logic       state_hold_o,
   input wire logic       dip_uncal_o,
   input wire logic       core_halt_o,
   input wire logic       timer01_halt_o,
   input wire logic       serial_halt_o,
   input wire logic       clk_halt_o,
   input wire logic       pin_freeze_o
);
   logic [2:0]  calm;
   logic [31:0] hi_cnt;
   logic        sw_flag;
   // Accepted writes only; writes in reset or hold are dropped
   wire ok_wr = sfr_wr_i && !sys_rst_o && !state_hold_o;
   wire sw_go = ok_wr && sfr_addr_i == 8'hf7 && sfr_wdata_i[0];
   wire mode_wr = ok_wr && sfr_addr_i == 8'h87;
   wire calm_now = !ext_pin_i && por_ok_i && ana_ok_i;
   // History of wake sources, so a pending pin reset is not taken for an irq wake
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         calm <= 3'h0;
         hi_cnt <= 32'h0;
         sw_flag <= 1'b0;
      end else begin
         calm <= {calm[1:0], calm_now};
         hi_cnt <= sys_rst_o ? hi_cnt + 32'h1 : 32'h0;
         if (sw_go) sw_flag <= 1'b1;
         else if (!sys_rst_o && hi_cnt != 32'h0) sw_flag <= 1'b0;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   pins_follow_rst_a: assert property (
      pins_high_o == sys_rst_o && dip_uncal_o == sys_rst_o) else $error("pin pull differs");
   sw_start_a: assert property (sw_go |=> sys_rst_o)
      else $error("software reset not started");
   sw_length_a: assert property ($fell(sys_rst_o) && sw_flag |->
      hi_cnt >= EXT_HOLD_CYC && hi_cnt <= EXT_HOLD_CYC + 1) else $error("sw reset length");
   idle_entry_a: assert property (mode_wr && sfr_wdata_i == 8'h01 ##1
      !irq_pending_i && !sys_rst_o |=> core_halt_o && timer01_halt_o && serial_halt_o
      && !clk_halt_o) else $error("idle not entered");
   idle_wake_a: assert property (core_halt_o && !clk_halt_o && irq_pending_i
      |-> ##[1:2] !core_halt_o) else $error("idle not left on irq");
   stop_entry_a: assert property (mode_wr && sfr_wdata_i == 8'h02 |-> ##2 clk_halt_o)
      else $error("stop not entered");
   stop_halts_all_a: assert property (clk_halt_o |-> core_halt_o && serial_halt_o
      && timer01_halt_o && pin_freeze_o) else $error("stop incomplete");
   freeze_only_stop_a: assert property (pin_freeze_o |-> clk_halt_o)
      else $error("pins frozen outside stop");
   stop_no_irq_a: assert property (clk_halt_o && irq_pending_i && calm == 3'h7
      && calm_now |=> clk_halt_o) else $error("irq woke stop");
   pin_reset_a: assert property (ext_pin_i [*3] |-> ##[0:3]
      sys_rst_o && osc_stop_o) else $error("pin reset not seen");
   dip_hold_a: assert property ((hardware_config_one_i[1] && dip_below_i) [*4]
      |-> ##[0:3] state_hold_o) else $error("dip hold missing");
   supply_hold_a: assert property ((!por_ok_i || !ana_ok_i) [*3]
      |-> ##[0:2] sys_rst_o) else $error("bad supply not held");
   reset_clears_a: assert property (sys_rst_o [*3] |-> !core_halt_o && !clk_halt_o)
      else $error("modes survive reset");
   cover property (sw_go);
   cover property ($rose(clk_halt_o));
   cover property ($rose(state_hold_o));
endmodule // rpmc_props

bind rpmc_top rpmc_props #(.EXT_HOLD_CYC(EXT_HOLD_CYC)) u_props (.clk_i, .rst_i, .por_ok_i,
   .ana_ok_i, .ext_pin_i, .dip_below_i, .hardware_config_one_i, .irq_pending_i, .sfr_addr_i,
   .sfr_wr_i, .sfr_wdata_i, .sys_rst_o, .pins_high_o, .osc_stop_o, .state_hold_o,
   .dip_uncal_o, .core_halt_o, .timer01_halt_o, .serial_halt_o, .clk_halt_o, .pin_freeze_o);

// [tb/rpmc_supply_model.sv]
`timescale 1ns/1ns
module rpmc_supply_model (
   input  wire logic clk_i,
   output logic      por_ok_o,
   output logic      ana_ok_o,
   output logic      dip_below_o,
   output logic      ext_pin_o
);
   // Supplies good and pin low from power-up
   initial begin
      por_ok_o = 1'b1;
      ana_ok_o = 1'b1;
      dip_below_o = 1'b0;
      ext_pin_o = 1'b0;
   end
   // Caller enters just after a rising edge; pin never shorter than two periods
   task automatic ext_pulse(input int n);
      ext_pin_o <= 1'b1;
      repeat (n < 2 ? 2 : n) @(posedge clk_i);
      ext_pin_o <= 1'b0;
   endtask
   task automatic supply(input logic por, input logic ana, input logic dip);
      por_ok_o <= por;
      ana_ok_o <= ana;
      dip_below_o <= dip;
   endtask
endmodule // rpmc_supply_model

// [tb/test_reset_and_power_mode_control.sv]
`timescale 1ns/1ns
module test_reset_and_power_mode_control;
   localparam integer EXT = 64;
   localparam integer DIP = 16;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [7:0] cfg0 = 8'h00;
   logic [7:0] cfg1 = 8'h00;
   logic       irq = 1'b0;
   logic [7:0] addr = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, periph;
   logic [3:0] lvl;
   logic       por, ana, dip, pin, srst, pins, osc, hold, uncal;
   logic       chalt, thalt, shalt, kh, frz;
   int         miscompares = 0;
   int         n_tests = 0;
   int         cyc = 0;
   rpmc_top #(.EXT_HOLD_CYC(EXT), .DIP_HOLD_CYC(DIP), .WDOG_SHIFT(2)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .por_ok_i(por), .ana_ok_i(ana), .dip_below_i(dip),
      .ext_pin_i(pin), .hardware_config_zero_i(cfg0), .hardware_config_one_i(cfg1),
      .irq_pending_i(irq), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
      .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sys_rst_o(srst), .pins_high_o(pins),
      .osc_stop_o(osc), .state_hold_o(hold), .dip_uncal_o(uncal), .dip_level_o(lvl),
      .core_halt_o(chalt), .timer01_halt_o(thalt), .serial_halt_o(shalt),
      .clk_halt_o(kh), .pin_freeze_o(frz), .periph_off_o(periph));
   rpmc_supply_model u_sup (.clk_i(clk_i), .por_ok_o(por), .ana_ok_o(ana),
      .dip_below_o(dip), .ext_pin_o(pin));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic check_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(posedge clk_i) #1;
      check(what, rdata, exp);
   endtask
   // Length of a reset pulse in cycles, both waits bounded
   task automatic rst_len(input string what, input int len, input int slack);
      int n;
      n = 0;
      while (srst !== 1'b1 && n < 40) begin
         @(posedge clk_i) #1 n++;
      end
      n = 0;
      while (srst === 1'b1 && n < len + 40) begin
         @(posedge clk_i) #1 n++;
      end
      check(what, n + 2 >= len && n <= len + slack, 1'b1);
   endtask
   task automatic t_regs();
      check_reg(8'h87, 8'h00, "power_control");
      check_reg(8'hf1, 8'h00, "peripheral_power_down");
      check_reg(8'hf7, 8'h01, "last cause");
      check_reg(8'hff, 8'h00, "watchdog_control");
      check_reg(8'h5a, 8'h00, "unmapped");
      wr_reg(8'hf1, 8'hff);
      @(posedge clk_i) #1;
      check("periph_off_o", periph, 8'hff);
      check_reg(8'hf1, 8'hff, "peripheral_power_down");
      wr_reg(8'hff, 8'h23);
      check_reg(8'hff, 8'h03, "kick reads zero");
      $display("t_regs done");
   endtask
   task automatic t_idle();
      wr_reg(8'h87, 8'h01);
      repeat (3) @(posedge clk_i);
      #1 check("idle halts", {chalt, thalt, shalt, kh, pins}, 5'b11100);
      check("periph kept", periph, 8'hff);
      @(posedge clk_i);
      irq <= 1'b1;
      @(posedge clk_i);
      irq <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1 check("idle wake", chalt, 1'b0);
      check_reg(8'h87, 8'h00, "idle bit cleared");
      $display("t_idle done");
   endtask
   task automatic t_stop();
      wr_reg(8'h87, 8'h02);
      repeat (3) @(posedge clk_i);
      #1 check("stop halts", {chalt, kh, frz}, 3'b111);
      @(posedge clk_i);
      irq <= 1'b1;
      repeat (4) @(posedge clk_i);
      irq <= 1'b0;
      #1 check("irq ignored", kh, 1'b1);
      @(posedge clk_i);
      u_sup.ext_pulse(5);
      #1 check("pin held", {osc, pins, srst, uncal}, 4'b1111);
      rst_len("pin reset", EXT, 12);
      check("stop left", kh, 1'b0);
      check_reg(8'hf7, 8'h02, "pin cause");
      $display("t_stop done");
   endtask
   task automatic t_sw();
      wr_reg(8'hf7, 8'h01);
      rst_len("sw reset", EXT, 2);
      check_reg(8'hf7, 8'h04, "sw cause");
      $display("t_sw done");
   endtask
   task automatic t_dip();
      @(posedge clk_i);
      u_sup.supply(1'b1, 1'b1, 1'b1);
      repeat (6) @(posedge clk_i);
      #1 check("dip disabled", {hold, srst}, 2'b00);
      @(posedge clk_i);
      cfg1 <= 8'h52;
      repeat (6) @(posedge clk_i);
      #1 check("dip level", lvl, 4'h5);
      check("dip hold", hold, 1'b1);
      wr_reg(8'h87, 8'h01);
      repeat (3) @(posedge clk_i);
      #1 check("write in hold", chalt, 1'b0);
      @(posedge clk_i);
      u_sup.supply(1'b1, 1'b1, 1'b0);
      rst_len("dip reset", DIP, 6);
      check_reg(8'hf7, 8'h10, "dip cause");
      $display("t_dip done");
   endtask
   task automatic t_por();
      wr_reg(8'h87, 8'h02);
      repeat (3) @(posedge clk_i);
      u_sup.supply(1'b0, 1'b1, 1'b0);
      repeat (6) @(posedge clk_i);
      #1 check("por held", {srst, pins, kh}, 3'b110);
      @(posedge clk_i);
      u_sup.supply(1'b1, 1'b0, 1'b0);
      repeat (20) @(posedge clk_i);
      #1 check("analog held", srst, 1'b1);
      @(posedge clk_i);
      u_sup.supply(1'b1, 1'b1, 1'b0);
      rst_len("supply release", 0, 10);
      check_reg(8'hf7, 8'h01, "por cause");
      $display("t_por done");
   endtask
   task automatic t_wdog();
      @(posedge clk_i);
      cfg0 <= 8'h08;
      wr_reg(8'hff, 8'h81);
      repeat (3) wr_reg(8'hff, 8'ha1);
      @(posedge clk_i) #1;
      check("kick holds off", srst, 1'b0);
      rst_len("watchdog reset", EXT, 2);
      @(posedge clk_i);
      cfg0 <= 8'h00;
      check_reg(8'hf7, 8'h08, "watchdog cause");
      $display("t_wdog done");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Cycle ceiling well above the few hundred cycles the tests take
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         miscompares++;
         wrap_up();
      end
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      t_regs();
      t_idle();
      t_stop();
      t_sw();
      t_dip();
      t_por();
      t_wdog();
      wrap_up();
   end
endmodule // test_reset_and_power_mode_control
